//--- flash_host_pkg.sv
// Package for the parallel flash bus host: pin bundles, operation codes and timing counts.
// Assumes a 40 MHz system clock; all times are converted to cycles here.
package flash_host_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int WORD_ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int SECTOR_MSB = 19;
  localparam int SECTOR_LSB = 12;
  localparam int SECTOR_W = 8;
  localparam int ADDR_BIT_OP = 6;
  localparam int ADDR_BIT_ONE = 1;
  localparam int ADDR_BIT_ZERO = 0;
  localparam int ADDR_BIT_ID = 9;
  localparam int BYTE_SEL_DQ = 15;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;

  // Times in ns with derived cycle counts; least times round up.
  localparam int ADDR_SETUP_NS = 50;
  localparam int WRITE_PULSE_NS = 50;
  localparam int WRITE_HOLD_NS = 50;
  localparam int ADDRESS_ACCESS_TIME_NS = 120;
  localparam int BUSY_TO_ACCESS_TIME_NS = 50;
  localparam int RESET_PULSE_TIME_NS = 500;
  localparam int RESET_HIGH_TIME_NS = 50;
  localparam int RESET_BUSY_TIME_NS = 20000;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int ADDR_SETUP_CYC = ns_to_cycles(ADDR_SETUP_NS);
  localparam int WRITE_PULSE_CYC = ns_to_cycles(WRITE_PULSE_NS);
  localparam int WRITE_HOLD_CYC = ns_to_cycles(WRITE_HOLD_NS);
  localparam int READ_ACCESS_CYC = ns_to_cycles(ADDRESS_ACCESS_TIME_NS);
  localparam int BUSY_TO_ACCESS_CYC = ns_to_cycles(BUSY_TO_ACCESS_TIME_NS);
  localparam int RESET_PULSE_CYC = ns_to_cycles(RESET_PULSE_TIME_NS);
  localparam int RESET_HIGH_CYC = ns_to_cycles(RESET_HIGH_TIME_NS);
  localparam int RESET_BUSY_CYC = ns_to_cycles(RESET_BUSY_TIME_NS);
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_PROTECT,
    OP_UNPROTECT,
    OP_VERIFY,
    OP_ID_READ,
    OP_RESET
  } op_t;

  typedef struct packed {
    op_t op;
    logic byte_mode;
    logic [WORD_ADDR_W-1:0] addr;
    logic byte_sel;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
    logic byte_width_sel_n;
    logic hw_reset_n;
    logic reset_hv;
    logic addr9_hv;
    logic [WORD_ADDR_W-1:0] addr;
  } pins_t;

endpackage : flash_host_pkg

//--- flash_dq_drive.sv
// Data bus driver for the flash host: splits write data by bus width.
// Assumes the caller holds drive low whenever output_enable_n is low.
`timescale 1ns/1ps
`default_nettype none
module flash_dq_drive (
  // Control
  input wire logic drive,
  input wire logic byte_mode,
  input wire logic byte_sel,
  input wire logic [flash_host_pkg::DATA_W-1:0] wdata,
  // Pin side
  output logic [flash_host_pkg::DATA_W-1:0] dq_out,
  output logic [flash_host_pkg::DATA_W-1:0] dq_oe
);
  import flash_host_pkg::*;

  always_comb begin
    dq_out = '0;
    dq_oe = '0;
    if (byte_mode) begin
      // In byte mode the top line carries the byte select, not data.
      dq_out[7:0] = wdata[7:0]; // R4
      dq_out[BYTE_SEL_DQ] = byte_sel; // R5
      dq_oe[7:0] = {8{drive}}; // R4
      dq_oe[BYTE_SEL_DQ] = 1'b1; // R5
    end else begin
      dq_out = wdata; // R4
      dq_oe = {DATA_W{drive}}; // R4
    end
  end

endmodule : flash_dq_drive
`default_nettype wire

//--- flash_bus_host.sv
// Host-side controller driving an asynchronous parallel flash through its pins.
// Assumes the flash pins are synchronous to clock and the far end answers within set times.
//
// Notes on behaviour
// R1: Writes hold chip select and write strobe low with output enable high.
// R2: Device latches address at later falling edge of write or chip select.
// R3: Device latches data at first rising edge of write or chip select.
// R4: Word mode drives all sixteen data lines, byte mode the low eight.
// R5: In byte mode the top data line carries the byte select address bit.
// R6: Byte mode addresses twenty word bits plus byte select; word mode twenty.
// R7: Device floats data in standby regardless of output enable.
// R8: Device finishes program or erase even if deselected.
// R9: Device sleeps after stable address for access time plus thirty ns.
// R10: In sleep the device keeps last data presented.
// R11: Sleep only happens in read mode.
// R12: Output enable high floats the device data bus.
// R13: Reset low aborts work, floats data, ignores accesses, returns to read.
// R14: Reset during busy: wait for ready, then busy-to-access time.
// R15: Reset while idle: done within pulse time; access after high time.
// R16: Device rejects program or erase to a protected sector.
// R17: All sectors start unprotected.
// R18: Protect all unprotected sectors before unprotect; unprotect clears all.
// R19: Protect and unprotect are writes with high voltage reset and coded address.
// R20: Verify read returns 01 for protected, 00 for unprotected sector.
// R21: High voltage on address bit nine reads identity codes on low byte.
// R22: High voltage on reset temporarily lifts protection.
// R23: High voltage conditions are separate digital qualifier outputs.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_host #(
  parameter int RESET_BUSY_CYCLES = flash_host_pkg::RESET_BUSY_CYC
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  output logic req_ready,
  input wire flash_host_pkg::req_t req,
  input wire logic temp_unprotect,
  // Answer side
  output logic rsp_valid,
  output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
  // Flash pins
  output flash_host_pkg::pins_t pins,
  output logic [flash_host_pkg::DATA_W-1:0] dq_out,
  output logic [flash_host_pkg::DATA_W-1:0] dq_oe,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  input wire logic ready_busy_n
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_PULSE,
    S_HOLD,
    S_READ,
    S_RST_LOW,
    S_RST_WAIT,
    S_RST_GAP
  } state_t;

  state_t state_q;
  req_t cur_q;
  logic [CNT_W-1:0] cnt_q;
  logic busy_at_reset_q;
  logic drive_q;
  logic rsp_valid_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic hv_op;
  logic [CNT_W-1:0] gap_last;

  // Builds the address pattern that selects a protection operation.
  function automatic logic [WORD_ADDR_W-1:0] prot_addr(input req_t r, input logic unprot);
    logic [WORD_ADDR_W-1:0] a;
    a = r.addr;
    a[ADDR_BIT_OP] = unprot; // R18 R19
    a[ADDR_BIT_ONE] = 1'b1; // R19
    a[ADDR_BIT_ZERO] = 1'b0; // R19
    return a;
  endfunction : prot_addr

  assign hv_op = (cur_q.op == OP_PROTECT) || (cur_q.op == OP_UNPROTECT);
  // The access gap after reset depends on whether the device was busy when it was hit.
  assign gap_last = busy_at_reset_q ? CNT_W'(BUSY_TO_ACCESS_CYC - 1) :
                    CNT_W'(RESET_HIGH_CYC - 1);
  assign req_ready = (state_q == S_IDLE);
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      busy_at_reset_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= '0;
          if (req_valid) begin
            if (req.op == OP_RESET) begin
              busy_at_reset_q <= ~ready_busy_n;
              state_q <= S_RST_LOW;
            end else if (req.op == OP_WRITE || req.op == OP_PROTECT ||
                         req.op == OP_UNPROTECT) begin
              state_q <= S_SETUP;
            end else begin
              state_q <= S_READ;
            end
          end
        end
        S_SETUP: begin
          // Address is stable before the strobes fall, so the later fall latches it.
          if (cnt_q == CNT_W'(ADDR_SETUP_CYC - 1)) begin // R2
            cnt_q <= '0;
            state_q <= S_PULSE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_PULSE: begin
          if (cnt_q == CNT_W'(WRITE_PULSE_CYC - 1)) begin // R3
            cnt_q <= '0;
            state_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_HOLD: begin
          if (cnt_q == CNT_W'(WRITE_HOLD_CYC - 1)) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_READ: begin
          if (cnt_q == CNT_W'(READ_ACCESS_CYC)) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_RST_LOW: begin
          if (cnt_q == CNT_W'(RESET_PULSE_CYC - 1)) begin // R15
            cnt_q <= '0;
            state_q <= busy_at_reset_q ? S_RST_WAIT : S_RST_GAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_RST_WAIT: begin
          // A stuck busy line is bounded by the internal reset time.
          if (ready_busy_n || cnt_q == CNT_W'(RESET_BUSY_CYCLES)) begin // R14
            cnt_q <= '0;
            state_q <= S_RST_GAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_RST_GAP: begin
          if (cnt_q == gap_last) begin // R14 R15
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Request capture.
  always_ff @(posedge clock) begin
    if (rst) begin
      cur_q <= '0;
    end else if (state_q == S_IDLE && req_valid) begin
      cur_q <= req;
    end
  end

  // Pin drive; output enable stays high for all writes.
  always_ff @(posedge clock) begin
    if (rst) begin
      pins <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_enable_n: 1'b1,
                byte_width_sel_n: 1'b1, hw_reset_n: 1'b1, reset_hv: 1'b0,
                addr9_hv: 1'b0, addr: '0};
      drive_q <= 1'b0;
    end else begin
      pins.byte_width_sel_n <= ~cur_q.byte_mode; // R4 R6
      pins.hw_reset_n <= !(state_q == S_RST_LOW); // R13
      // Protect and unprotect need high voltage on reset; so does temporary unprotect.
      pins.reset_hv <= (hv_op && (state_q == S_SETUP || state_q == S_PULSE || // R19 R22 R23
                        state_q == S_HOLD)) || (temp_unprotect && state_q != S_RST_LOW);
      pins.addr9_hv <= (state_q == S_READ) && (cur_q.op == OP_ID_READ ||
                        cur_q.op == OP_VERIFY); // R21 R23
      if (state_q == S_SETUP || state_q == S_PULSE || state_q == S_HOLD) begin
        pins.addr <= hv_op ? prot_addr(cur_q, cur_q.op == OP_UNPROTECT) : cur_q.addr; // R6
        pins.output_enable_n <= 1'b1; // R1
        pins.chip_select_n <= !(state_q == S_PULSE); // R1
        pins.write_strobe_n <= !(state_q == S_PULSE); // R1
        drive_q <= 1'b1;
      end else if (state_q == S_READ) begin
        if (cur_q.op == OP_VERIFY) begin
          pins.addr <= prot_addr(cur_q, 1'b0); // R20
        end else begin
          pins.addr <= cur_q.addr;
        end
        pins.chip_select_n <= 1'b0;
        pins.write_strobe_n <= 1'b1;
        pins.output_enable_n <= 1'b0;
        drive_q <= 1'b0;
      end else begin
        pins.chip_select_n <= 1'b1;
        pins.write_strobe_n <= 1'b1;
        pins.output_enable_n <= 1'b1;
        drive_q <= 1'b0;
      end
    end
  end

  // Read answer; the device floats the upper byte in byte mode, so it is masked.
  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= (state_q == S_READ) && (cnt_q == CNT_W'(READ_ACCESS_CYC));
      if (state_q == S_READ && cnt_q == CNT_W'(READ_ACCESS_CYC)) begin
        if (cur_q.op == OP_VERIFY) begin
          rsp_data_q <= {8'h00, dq_in[7:0]}; // R20
        end else if (cur_q.byte_mode) begin
          rsp_data_q <= {8'h00, dq_in[7:0]}; // R21
        end else begin
          rsp_data_q <= dq_in;
        end
      end
    end
  end

  flash_dq_drive u_dq (
    .drive(drive_q),
    .byte_mode(cur_q.byte_mode),
    .byte_sel(cur_q.byte_sel),
    .wdata(cur_q.wdata),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

endmodule : flash_bus_host
`default_nettype wire

//--- flash_bus_host_sva.sv
// Pin-level assertions for the flash host controller.
// Assumes it is bound to flash_bus_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_host_sva (
  // System
  input wire logic clock,
  input wire logic rst,
  // Flash pins
  input wire flash_host_pkg::pins_t pins,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_oe,
  input wire logic ready_busy_n
);
  import flash_host_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int low_run;
  // The reset pulse is checked when reset rises, so its length in cycles is counted here, up to 1000.
  always_ff @(posedge clock) begin
    if (rst || pins.hw_reset_n) begin
      low_run <= 0;
    end else if (low_run < 1000) begin
      low_run <= low_run + 1;
    end
  end
  a_write_oe_off: assert property (
    !pins.write_strobe_n |-> pins.output_enable_n && !pins.chip_select_n)
    else $error("write strobe low without select or with output enable low");
  a_addr_held: assert property (!pins.write_strobe_n |-> $stable(pins.addr))
    else $error("address moved during write pulse");
  a_word_drive: assert property (
    !pins.write_strobe_n && pins.byte_width_sel_n |-> dq_oe == 16'hFFFF)
    else $error("word write not driving all data lines");
  a_byte_drive: assert property (
    !pins.write_strobe_n && !pins.byte_width_sel_n |-> dq_oe == 16'h80FF)
    else $error("byte write drive pattern wrong");
  a_read_release: assert property (!pins.output_enable_n |-> dq_oe[14:0] == 15'h0000)
    else $error("host drives data while device outputs enabled");
  a_reset_quiet: assert property (
    !pins.hw_reset_n |-> pins.chip_select_n && pins.write_strobe_n)
    else $error("access during reset pulse");
  a_reset_width: assert property ($rose(pins.hw_reset_n) |-> low_run >= RESET_PULSE_CYC)
    else $error("reset pulse too short");
  a_reset_gap: assert property ($rose(pins.hw_reset_n) |-> pins.chip_select_n [*2])
    else $error("access too soon after reset");
  a_busy_gap: assert property ($rose(ready_busy_n) |-> pins.chip_select_n [*2])
    else $error("access too soon after ready");
endmodule : flash_bus_host_sva
`default_nettype wire

//--- flash_dev_model.sv
// Behavioural flash device seen from its pins, with sector protection.
// Assumes pins change only at the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5C, // Arbitrary value.
  parameter logic [15:0] PART_CODE = 16'h3E71 // Arbitrary value.
) (
  // System
  input wire logic clock,
  // Host side
  input wire flash_host_pkg::pins_t pins,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_out,
  // Device side
  output logic [flash_host_pkg::DATA_W-1:0] dq_in,
  output logic ready_busy_n
);
  import flash_host_pkg::*;
  logic [255:0] prot = '0;
  logic [19:0] lat_a;
  logic [15:0] last_w, word;
  logic [15:0] pat = 16'h5A5A;
  logic last_b;
  logic wr_q = 1'b0;
  logic rst_q = 1'b1;
  logic wr;
  int busy = 0;
  assign wr = !pins.chip_select_n && !pins.write_strobe_n && pins.hw_reset_n;
  assign ready_busy_n = (busy == 0);
  always @(posedge clock) begin
    pat <= ~pat;
    wr_q <= wr;
    rst_q <= pins.hw_reset_n;
    if (busy > 0) busy <= busy - 1;
    if (!pins.hw_reset_n && rst_q && busy > 0) busy <= 30;
    if (wr && !wr_q) lat_a <= pins.addr;
    if (!wr && wr_q && pins.hw_reset_n) begin
      last_w <= pins.byte_width_sel_n ? dq_out : {8'h00, dq_out[7:0]};
      last_b <= dq_out[15];
      if (pins.reset_hv && lat_a[1] && !lat_a[0]) begin
        if (lat_a[6]) prot <= '0;
        else prot[lat_a[19:12]] <= 1'b1;
      end else if (!prot[lat_a[19:12]] || pins.reset_hv) busy <= 40;
    end
  end
  // Data follow the address at once and then rest, so sleep looks like a plain read.
  always_comb begin
    if (pins.addr9_hv) begin
      word = {8'h00, prot[pins.addr[19:12]] ? PROT_YES : PROT_NO};
      if (!pins.addr[1]) word = pins.addr[0] ? PART_CODE : {8'h00, MAKER_CODE};
    end else word = pins.addr[15:0] ^ 16'hA55A;
    if (!pins.byte_width_sel_n) word = {pat[15:8], dq_out[15] ? word[15:8] : word[7:0]};
    dq_in = (!pins.chip_select_n && !pins.output_enable_n && pins.hw_reset_n) ? word
            : pat;
  end
endmodule : flash_dev_model
`default_nettype wire

//--- flash_bus_host_tb_top.sv
// Self-checking bench for the flash host against a behavioural flash model.
// Assumes the checker and the model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_host_tb_top;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h5C; // Arbitrary value.
  localparam logic [15:0] PART = 16'h3E71; // Arbitrary value.
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic temp_unprotect = 1'b0;
  logic req_ready, rsp_valid, ready_busy_n;
  req_t req = '0;
  pins_t pins;
  logic [15:0] rsp_data, dq_out, dq_oe, dq_in, rd;
  logic [31:0] rng = 32'h5;
  logic [255:0] prot_m = '0;
  int err_count = 0;
  int n_checks = 0;
  int low_cyc = 0;
  int c0;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (pins.hw_reset_n === 1'b0) low_cyc <= low_cyc + 1;
  end
  flash_bus_host #(.RESET_BUSY_CYCLES(20)) i_flash_bus_host (.clock(clock), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .temp_unprotect(temp_unprotect),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash_dev_model (.clock(clock),
    .pins(pins), .dq_out(dq_out), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [15:0] exp_rd(input logic bm, input logic bs, input logic [19:0] a);
    logic [15:0] w;
    w = a[15:0] ^ 16'hA55A;
    return bm ? {8'h00, bs ? w[15:8] : w[7:0]} : w;
  endfunction : exp_rd
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Holds the request until taken, then waits for idle and ready, but only one cycle after a write; the answer lands in rd.
  task automatic xfer(input op_t op, input logic bm, input logic [19:0] a, input logic bs,
                      input logic [15:0] wd);
    int n;
    n = 0;
    rd = 'x;
    req_valid <= 1'b1;
    req <= '{op, bm, a, bs, wd};
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    do begin
      @(posedge clock);
      n++;
      if (rsp_valid === 1'b1) rd = rsp_data;
    end while ((req_ready !== 1'b1 || ready_busy_n !== 1'b1) && n < 400 && op != OP_WRITE);
    if (n >= 400) begin
      err_count++;
      end_sim();
    end
  endtask : xfer
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      xfer(OP_READ, rng[20], rng[19:0], rng[21], 16'h0000);
      check(rd, exp_rd(rng[20], rng[21], rng[19:0]));
    end
    $display("read test done");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      temp_unprotect <= rng[22];
      xfer(OP_WRITE, rng[20], {rng[19:1], 1'b1}, rng[21], rng[31:16]);
      xfer(OP_READ, 1'b0, 20'h00000, 1'b0, 16'h0000);
      check(i_flash_dev_model.last_w, rng[20] ? {8'h00, rng[23:16]} : rng[31:16]);
      check(i_flash_dev_model.lat_a, {rng[19:1], 1'b1});
      if (rng[20]) check(i_flash_dev_model.last_b, rng[21]);
    end
    temp_unprotect <= 1'b0;
    $display("write test done");
    xfer(OP_ID_READ, 1'b0, 20'h00000, 1'b0, 16'h0000);
    check(rd, {8'h00, MAKER});
    xfer(OP_ID_READ, 1'b0, 20'h00001, 1'b0, 16'h0000);
    check(rd, PART);
    c0 = rng[7:0];
    xfer(OP_VERIFY, 1'b0, {c0[7:0], 12'h000}, 1'b0, 16'h0000);
    check(rd, PROT_NO);
    for (int s = 0; s < 256; s++) begin
      if (!prot_m[s]) xfer(OP_PROTECT, 1'b0, {s[7:0], 12'h000}, 1'b0, 16'h0000);
      prot_m[s] = 1'b1;
      if (s == c0) xfer(OP_VERIFY, 1'b0, {c0[7:0], 12'h000}, 1'b0, 16'h0000);
      if (s == c0) check(rd, PROT_YES);
    end
    xfer(OP_WRITE, 1'b0, {c0[7:0], 12'h001}, 1'b0, 16'h00C3);
    repeat (8) @(posedge clock);
    check(ready_busy_n, 1'b1);
    temp_unprotect <= 1'b1;
    xfer(OP_WRITE, 1'b0, {c0[7:0], 12'h001}, 1'b0, 16'h003C);
    repeat (8) @(posedge clock);
    check(ready_busy_n, 1'b0);
    temp_unprotect <= 1'b0;
    xfer(OP_READ, 1'b0, 20'h00000, 1'b0, 16'h0000);
    xfer(OP_UNPROTECT, 1'b0, 20'h00000, 1'b0, 16'h0000);
    prot_m = '0;
    for (int s = 0; s < 256; s += 51) begin
      xfer(OP_VERIFY, 1'b0, {s[7:0], 12'h000}, 1'b0, 16'h0000);
      check(rd, {15'h0000, prot_m[s]});
    end
    $display("protect test done");
    c0 = low_cyc;
    xfer(OP_RESET, 1'b0, 20'h00000, 1'b0, 16'h0000);
    check(20'(low_cyc - c0), 20'(RESET_PULSE_CYC));
    xfer(OP_WRITE, 1'b0, 20'h00011, 1'b0, 16'h1234);
    c0 = low_cyc;
    xfer(OP_RESET, 1'b0, 20'h00000, 1'b0, 16'h0000);
    check(20'(low_cyc - c0), 20'(RESET_PULSE_CYC));
    check(ready_busy_n, 1'b1);
    $display("reset test done");
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    end_sim();
  end
endmodule : flash_bus_host_tb_top
bind flash_bus_host flash_bus_host_sva i_sva (.clock(clock), .rst(rst), .pins(pins),
  .dq_oe(dq_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire
